/* logic/seid_loader.sv */
// Top: serial EEPROM identification loader and infrared start-up strap
`timescale 1ns/1ps

// Summary of operation
// - Auto read clocks the EEPROM at bus clock divided by 256.
// - Auto read of identification runs after power-up and every reset.
// - Outside auto read, software toggles the serial clock via control bit.
// - Outside auto read, software drives the EEPROM select directly via control bit.
// - At power-up the pulled-up select line senses EEPROM presence.
// - In manual access the write line follows a software control bit.
// - Software can read the level of the EEPROM read line.
// - Auto loader addresses and shifts the EEPROM as 16-bit words.
// - Infrared strap is sampled after power-up, hardware reset and soft reset.
// - Sampled strap goes to modem control bit 6 of all four channels.
// - Software may then write the infrared bit freely until next reset.
// - EEPROM contents only supply the four identification values.
// - Without loaded EEPROM data, built-in identification values are reported.
module seid_loader
  import seid_pkg::*;
(
  // Clock and resets
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic                     soft_reset,
  // EEPROM pins; select is two-way for presence sensing
  output logic                          eeprom_serial_clock,
  output logic                          eeprom_select_out,
  output logic                          eeprom_select_oe,
  input  wire logic                     eeprom_select_in,
  output logic                          eeprom_write_line,
  input  wire logic                     eeprom_read_line,
  // Control register bits for manual access
  input  wire seid_eectl_t              eeprom_manual,
  output logic                          eeprom_read_level,
  // Loader status
  output logic                          load_busy,
  output logic                          eeprom_present,
  output logic                          ids_from_eeprom,
  // Identification values for configuration space
  output seid_ids_t                     ids,
  // Infrared strap and modem control bit 6 per channel
  input  wire logic                     infrared_startup_strap,
  input  wire logic [SEID_CHANNELS-1:0] ir_write,
  input  wire logic [SEID_CHANNELS-1:0] ir_write_value,
  output logic      [SEID_CHANNELS-1:0] modem_control_ir
);

  // ==========================================================================
  // Synchronised pin inputs
  logic [2:0] pins_sync;
  logic       select_sync;
  logic       read_sync;
  logic       strap_sync;

  seid_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in ({eeprom_select_in, eeprom_read_line, infrared_startup_strap}),
    .sync_out (pins_sync)
  );

  assign select_sync = pins_sync[2];
  assign read_sync   = pins_sync[1];
  assign strap_sync  = pins_sync[0];

  // ==========================================================================
  // Read command bit for a frame position, MSB first
  function automatic logic cmd_bit(input logic [4:0] pos, input logic [1:0] word);
    logic [SEID_CMD_BITS-1:0] cmd;
    cmd = {SEID_READ_OPCODE, 4'h0, word};
    if (pos < SEID_DATA_FIRST)
      cmd_bit = cmd[4'(SEID_CMD_BITS - 1) - pos[3:0]];
    else
      cmd_bit = 1'b0;
  endfunction

  // ==========================================================================
  // Loader state
  seid_state_t          state_reg;
  seid_state_t          state_next;
  logic [7:0]           div_reg;
  logic [3:0]           sense_reg;
  logic [4:0]           bit_reg;
  logic [1:0]           word_reg;
  logic [15:0]          shift_reg;
  logic [15:0]          words_reg [SEID_NUM_WORDS];
  logic                 present_reg;
  logic                 loaded_reg;
  logic                 write_reg;
  logic                 div_wrap;
  logic                 sense_end;

  assign div_wrap  = (div_reg == SEID_DIV_LAST);
  assign sense_end = (sense_reg == SEID_SENSE_CYCLES);

  // ==========================================================================
  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SEID_ST_SENSE:
      begin
        if (sense_end)
          state_next = select_sync ? SEID_ST_SELECT : SEID_ST_DONE;
      end
      SEID_ST_SELECT:
      begin
        if (div_wrap)
          state_next = SEID_ST_SHIFT;
      end
      SEID_ST_SHIFT:
      begin
        if (div_wrap && bit_reg == SEID_FRAME_LAST)
          state_next = SEID_ST_GAP;
      end
      SEID_ST_GAP:
      begin
        if (div_wrap)
          state_next = (word_reg == SEID_WORD_LAST) ? SEID_ST_DONE : SEID_ST_SELECT;
      end
      SEID_ST_DONE:
        state_next = SEID_ST_DONE;
      default:
        state_next = SEID_ST_SENSE;
    endcase
  end

  // Soft reset restarts the whole sequence like a hardware reset
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_reg <= SEID_ST_SENSE;
    else if (soft_reset)
      state_reg <= SEID_ST_SENSE;
    else
      state_reg <= state_next;
  end

  // ==========================================================================
  // Presence sensing window: select released so the pull-up shows
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sense_reg   <= SEID_SENSE_RESET;
      present_reg <= 1'b0;
    end
    else if (soft_reset)
    begin
      sense_reg   <= SEID_SENSE_RESET;
      present_reg <= 1'b0;
    end
    else if (state_reg == SEID_ST_SENSE)
    begin
      sense_reg <= sense_reg + 4'h1;
      if (sense_end)
        present_reg <= select_sync;
    end
  end

  // ==========================================================================
  // Serial clock divider, free during the automatic read
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      div_reg <= SEID_DIV_RESET;
    else if (soft_reset || state_reg == SEID_ST_SENSE || state_reg == SEID_ST_DONE)
      div_reg <= SEID_DIV_RESET;
    else
      div_reg <= div_reg + 8'h01;
  end

  // ==========================================================================
  // Frame bit position, word index and write data
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      bit_reg   <= SEID_BIT_RESET;
      word_reg  <= SEID_WORD_RESET;
      write_reg <= 1'b0;
    end
    else if (soft_reset)
    begin
      bit_reg   <= SEID_BIT_RESET;
      word_reg  <= SEID_WORD_RESET;
      write_reg <= 1'b0;
    end
    else if (div_wrap)
    begin
      case (state_reg)
        SEID_ST_SELECT:
        begin
          bit_reg   <= SEID_BIT_RESET;
          write_reg <= cmd_bit(SEID_BIT_RESET, word_reg);
        end
        SEID_ST_SHIFT:
        begin
          // Data changes while the serial clock falls
          bit_reg   <= bit_reg + 5'h01;
          write_reg <= cmd_bit(bit_reg + 5'h01, word_reg);
        end
        SEID_ST_GAP:
        begin
          write_reg <= 1'b0;
          if (word_reg != SEID_WORD_LAST)
            word_reg <= word_reg + 2'h1;
        end
        default:
          write_reg <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Data capture: sampled late in the high phase, long after the rising edge
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      shift_reg <= '0;
    else if (state_reg == SEID_ST_SHIFT && div_wrap && bit_reg >= SEID_DATA_FIRST)
      shift_reg <= {shift_reg[14:0], read_sync};
  end

  // Word store; a word is only complete after its last sample
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < SEID_NUM_WORDS; i++)
        words_reg[i] <= '0;
    end
    else if (state_reg == SEID_ST_GAP && div_reg == SEID_DIV_RESET)
      words_reg[word_reg] <= shift_reg;
  end

  // ==========================================================================
  // Identification values are committed together, never half-loaded
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      loaded_reg <= 1'b0;
      ids        <= {SEID_DEF_VENDOR, SEID_DEF_DEVICE, SEID_DEF_SUB_VENDOR, SEID_DEF_SUB_ID};
    end
    else if (soft_reset)
    begin
      loaded_reg <= 1'b0;
      ids        <= {SEID_DEF_VENDOR, SEID_DEF_DEVICE, SEID_DEF_SUB_VENDOR, SEID_DEF_SUB_ID};
    end
    else if (state_reg == SEID_ST_GAP && div_wrap && word_reg == SEID_WORD_LAST)
    begin
      loaded_reg <= 1'b1;
      ids        <= {words_reg[0], words_reg[1], words_reg[2], words_reg[3]};
    end
  end

  // ==========================================================================
  // EEPROM pin drive: automatic read owns the pins, otherwise software
  always_comb
  begin
    case (state_reg)
      SEID_ST_SENSE:
      begin
        eeprom_select_out   = 1'b0;
        eeprom_select_oe    = 1'b0;
        eeprom_serial_clock = 1'b0;
        eeprom_write_line   = 1'b0;
      end
      SEID_ST_SELECT, SEID_ST_GAP:
      begin
        eeprom_select_out   = (state_reg == SEID_ST_SELECT);
        eeprom_select_oe    = 1'b1;
        eeprom_serial_clock = 1'b0;
        eeprom_write_line   = write_reg;
      end
      SEID_ST_SHIFT:
      begin
        eeprom_select_out   = 1'b1;
        eeprom_select_oe    = 1'b1;
        eeprom_serial_clock = div_reg[SEID_DIV_W-1];
        eeprom_write_line   = write_reg;
      end
      default:
      begin
        eeprom_select_out   = eeprom_manual.select;
        eeprom_select_oe    = 1'b1;
        eeprom_serial_clock = eeprom_manual.clock;
        eeprom_write_line   = eeprom_manual.write;
      end
    endcase
  end

  assign eeprom_read_level = read_sync;
  assign load_busy         = (state_reg != SEID_ST_DONE);
  assign eeprom_present    = present_reg;
  assign ids_from_eeprom   = loaded_reg;

  // ==========================================================================
  // Infrared enable per channel: strap copy at end of sensing, then software
  genvar ch;
  generate
    for (ch = 0; ch < SEID_CHANNELS; ch++)
    begin : g_ir
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
          modem_control_ir[ch] <= SEID_IR_RESET[ch];
        else if (soft_reset)
          modem_control_ir[ch] <= SEID_IR_RESET[ch];
        else if (state_reg == SEID_ST_SENSE && sense_end)
          modem_control_ir[ch] <= strap_sync;
        else if (ir_write[ch])
          modem_control_ir[ch] <= ir_write_value[ch];
      end
    end
  endgenerate

endmodule // seid_loader

/* logic/seid_pkg.sv */
// Package: constants and carrier types for the serial EEPROM identification loader
package seid_pkg;

  // ==========================================================================
  // Serial clock divider
  localparam int         SEID_CLK_DIV      = 256;
  localparam int         SEID_DIV_W        = $clog2(SEID_CLK_DIV);
  localparam logic [7:0] SEID_DIV_RESET    = 8'h00;
  localparam logic [7:0] SEID_DIV_LAST     = 8'(SEID_CLK_DIV - 1);

  // ==========================================================================
  // Read frame layout: start bit, read opcode, 6-bit word address, 16 data bits
  localparam int         SEID_CMD_BITS     = 9;
  localparam logic [2:0] SEID_READ_OPCODE  = 3'h6;
  localparam int         SEID_ADDR_BITS    = 6;
  localparam int         SEID_WORD_BITS    = 16;
  localparam int         SEID_FRAME_BITS   = SEID_CMD_BITS + SEID_WORD_BITS;
  localparam logic [4:0] SEID_FRAME_LAST   = 5'(SEID_FRAME_BITS - 1);
  localparam logic [4:0] SEID_DATA_FIRST   = 5'(SEID_CMD_BITS);
  localparam logic [4:0] SEID_BIT_RESET    = 5'h00;

  // Words fetched: 0 vendor, 1 device, 2 subsystem vendor, 3 subsystem
  localparam int         SEID_NUM_WORDS    = 4;
  localparam logic [1:0] SEID_WORD_LAST    = 2'(SEID_NUM_WORDS - 1);
  localparam logic [1:0] SEID_WORD_RESET   = 2'h0;

  // ==========================================================================
  // Presence sensing window on the released select line (cycles)
  localparam logic [3:0] SEID_SENSE_CYCLES = 4'h8;
  localparam logic [3:0] SEID_SENSE_RESET  = 4'h0;

  // ==========================================================================
  // Built-in identification values; all four values are arbitrary
  localparam logic [15:0] SEID_DEF_VENDOR     = 16'h1234;
  localparam logic [15:0] SEID_DEF_DEVICE     = 16'h0004;
  localparam logic [15:0] SEID_DEF_SUB_VENDOR = 16'h1234;
  localparam logic [15:0] SEID_DEF_SUB_ID     = 16'h0000;

  // ==========================================================================
  // Channel count for the infrared enable bit
  localparam int          SEID_CHANNELS       = 4;
  localparam logic [3:0]  SEID_IR_RESET       = 4'h0;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] device;
    logic [15:0] sub_vendor;
    logic [15:0] sub_id;
  } seid_ids_t;

  typedef struct packed {
    logic select;
    logic clock;
    logic write;
  } seid_eectl_t;

  typedef enum logic [4:0] {
    SEID_ST_SENSE  = 5'b00001,
    SEID_ST_SELECT = 5'b00010,
    SEID_ST_SHIFT  = 5'b00100,
    SEID_ST_GAP    = 5'b01000,
    SEID_ST_DONE   = 5'b10000
  } seid_state_t;

endpackage

/* logic/seid_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps

module seid_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // seid_sync

/* tb/seid_eeprom_model.sv */
// Behavioural serial EEPROM holding four identification words
`timescale 1ns/1ps

module seid_eeprom_model #(
  parameter logic [63:0] WORDS = 64'hA5C35A3C0FF0C00F
) (
  // Bus clock and pins
  input  wire logic clock,
  input  wire logic sel,
  input  wire logic sck,
  input  wire logic din,
  output logic      dout
);
  logic [8:0]  cmd_reg = 9'h000;
  logic [15:0] sh_reg  = 16'h0000;
  logic        sck_reg = 1'b0;
  int          n_reg   = 0;
  initial dout = 1'b0;
  // ==========================================================================
  // Released output toggles so a stale level is never mistaken for data
  always @(posedge clock)
  begin
    sck_reg <= sck;
    if (!sel)
    begin
      n_reg <= 0;
      dout  <= ~dout;
    end
    else if (sck && !sck_reg)
    begin
      n_reg   <= n_reg + 1;
      cmd_reg <= {cmd_reg[7:0], din};
      if (n_reg == 8)
      begin
        dout   <= 1'b0;
        sh_reg <= ({cmd_reg[7:0], din} >> 2 == 7'h60) ? WORDS[63 - 16 * din - 32 * cmd_reg[0] -: 16]
                                                       : 16'h9696;
      end
      else if (n_reg > 8)
      begin
        dout   <= sh_reg[15];
        sh_reg <= {sh_reg[14:0], 1'b0};
      end
    end
  end
endmodule // seid_eeprom_model

/* tb/seid_loader_checker.sv */
// Checker: port-level assertions for the identification loader
`timescale 1ns/1ps

module seid_loader_checker
  import seid_pkg::*;
(
  // Clock and resets
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        soft_reset,
  // EEPROM pins and manual bits
  input wire logic        eeprom_serial_clock,
  input wire logic        eeprom_select_out,
  input wire logic        eeprom_select_oe,
  input wire logic        eeprom_select_in,
  input wire logic        eeprom_write_line,
  input wire logic        eeprom_read_line,
  input wire seid_eectl_t eeprom_manual,
  input wire logic        eeprom_read_level,
  // Status, ids and infrared bits
  input wire logic        load_busy,
  input wire logic        eeprom_present,
  input wire logic        ids_from_eeprom,
  input wire seid_ids_t   ids,
  input wire logic        infrared_startup_strap,
  input wire logic [3:0]  ir_write,
  input wire logic [3:0]  ir_write_value,
  input wire logic [3:0]  modem_control_ir
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Helpers: cycles since serial clock change, cycles select held high
  logic [7:0]  half_cnt;
  logic [12:0] sel_cnt;
  always_ff @(posedge clock or posedge reset)
    if (reset) half_cnt <= 8'h00;
    else if ($changed(eeprom_serial_clock)) half_cnt <= 8'h00;
    else half_cnt <= half_cnt + 8'h01;
  always_ff @(posedge clock or posedge reset)
    if (reset) sel_cnt <= 13'h0000;
    else sel_cnt <= eeprom_select_out ? sel_cnt + 13'h0001 : 13'h0000;
  sequence frame_start;
    $rose(eeprom_select_out) && load_busy;
  endsequence
  sequence steady_line;
    (!load_busy && $stable(eeprom_read_line))[*4];
  endsequence
  // ==========================================================================
  // Assertions
  half_period_a: assert property ($fell(eeprom_serial_clock) && load_busy && !$past(soft_reset)
    |-> half_cnt == 8'h7F) else $error("serial clock high phase not 128 cycles");
  frame_len_a: assert property ($fell(eeprom_select_out) && load_busy && !$past(soft_reset)
    |-> sel_cnt == 13'h1A00) else $error("select not held for 26 serial periods");
  start_bit_a: assert property (frame_start |-> ##256
    (eeprom_write_line && !eeprom_serial_clock) ##128 eeprom_serial_clock)
    else $error("frame start wrong");
  man_pins_a: assert property (!load_busy |-> eeprom_serial_clock == eeprom_manual.clock
    && eeprom_select_out == eeprom_manual.select && eeprom_select_oe
    && eeprom_write_line == eeprom_manual.write) else $error("manual pins differ");
  read_level_a: assert property (steady_line |-> eeprom_read_level == eeprom_read_line)
    else $error("read level differs from line");
  ir_write_a: assert property (|ir_write && !soft_reset && !load_busy |=>
    ((modem_control_ir ^ $past(ir_write_value)) & $past(ir_write)) == 4'h0)
    else $error("infrared bit write lost");
  strap_copy_a: assert property ($rose(eeprom_select_oe) |-> ##1
    modem_control_ir == {4{infrared_startup_strap}}) else $error("strap not copied");
  presence_a: assert property ($rose(eeprom_select_oe) |-> ##1
    eeprom_present == $past(eeprom_select_in, 2)) else $error("presence not sensed");
  def_ids_a: assert property (!ids_from_eeprom |-> ids == {SEID_DEF_VENDOR, SEID_DEF_DEVICE,
    SEID_DEF_SUB_VENDOR, SEID_DEF_SUB_ID}) else $error("default ids not shown");
  load_done_a: assert property ($fell(load_busy) |-> ids_from_eeprom == eeprom_present)
    else $error("load result wrong");
endmodule // seid_loader_checker

/* tb/seid_loader_tb.sv */
// Testbench: auto read, manual access, soft reset and absent EEPROM
`timescale 1ns/1ps

module seid_loader_tb
  import seid_pkg::*;
;
  localparam logic [63:0] W   = 64'hA5C35A3C0FF0C00F;
  localparam logic [63:0] DEF = {SEID_DEF_VENDOR, SEID_DEF_DEVICE, SEID_DEF_SUB_VENDOR,
                                 SEID_DEF_SUB_ID};
  logic clock, reset, soft_reset, fitted, strap, sck, sel_o, sel_oe, sel, wr, rd, lvl;
  logic busy, present, loaded;
  logic [3:0] ir_write, ir_value, mcr_ir;
  seid_eectl_t manual;
  seid_ids_t   ids;
  int failures = 0;
  int n_compared = 0;
  logic [15:0] got;
  logic r;
  // ==========================================================================
  // Select wire: pull-up only when an EEPROM is fitted
  assign sel = sel_oe ? sel_o : fitted;
  seid_loader i_dut (.clock(clock), .reset(reset), .soft_reset(soft_reset),
    .eeprom_serial_clock(sck), .eeprom_select_out(sel_o), .eeprom_select_oe(sel_oe),
    .eeprom_select_in(sel), .eeprom_write_line(wr), .eeprom_read_line(rd),
    .eeprom_manual(manual), .eeprom_read_level(lvl), .load_busy(busy),
    .eeprom_present(present), .ids_from_eeprom(loaded), .ids(ids),
    .infrared_startup_strap(strap), .ir_write(ir_write), .ir_write_value(ir_value),
    .modem_control_ir(mcr_ir));
  seid_eeprom_model #(.WORDS(W)) i_rom (.clock(clock), .sel(sel & fitted), .sck(sck),
    .din(wr), .dout(rd));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 30000 && busy !== 1'b0; i++)
      @(posedge clock);
    check("load_busy", busy, 0);
  endtask
  task automatic man_bit(input logic b, output logic q);
    manual <= '{1'b1, 1'b0, b};
    repeat (4) @(posedge clock);
    manual.clock <= 1'b1;
    repeat (6) @(posedge clock);
    q = lvl;
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    reset = 1'b1; soft_reset = 1'b0; fitted = 1'b1; strap = 1'b1;
    manual = 3'h0; ir_write = 4'h0; ir_value = 4'h0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    repeat (12) @(posedge clock);
    check("present", present, 1);
    check("strap copy", mcr_ir, 4'hF);
    check("ids before load", ids, DEF);
    wait_idle();
    check("ids loaded", ids, W);
    check("loaded flag", loaded, 1);
    ir_write <= 4'h5;
    ir_value <= 4'h1;
    @(posedge clock);
    ir_write <= 4'h0;
    @(posedge clock);
    check("ir override", mcr_ir, 4'hB);
    // Software reads word 2 by hand; dummy bit skipped
    for (int i = 24; i >= 0; i--)
    begin
      man_bit(i > 15 ? 1'(9'h182 >> (i - 16)) : 1'b0, r);
      if (i < 16)
        got = {got[14:0], r};
    end
    manual <= 3'h0;
    check("manual word", got, W[31:16]);
    // Abort in the gap after word 0, with strap low
    strap <= 1'b0;
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    repeat (6700) @(posedge clock);
    check("gap select", sel_o, 0);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    repeat (12) @(posedge clock);
    check("ids after abort", ids, DEF);
    check("strap low", mcr_ir, 4'h0);
    wait_idle();
    check("ids reloaded", ids, W);
    // No EEPROM fitted: line pulled low
    fitted <= 1'b0;
    reset <= 1'b1;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    wait_idle();
    check("absent", present, 0);
    check("default ids", ids, DEF);
    check("not loaded", loaded, 0);
    stop_test();
  end
  // Watchdog: full run is about 62000 cycles
  initial
  begin
    repeat (90000) @(posedge clock);
    failures++;
    stop_test();
  end
endmodule // seid_loader_tb

bind seid_loader seid_loader_checker i_chk (.*);
